// ==== hw/nvsq_pkg.sv ====
// Package for the nonvolatile SRAM host controller: pins, commands, map, timing
package nvsq_pkg;

   // Software port map (word addresses)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_ADDR = 4'h1;
   localparam logic [3:0] ADDR_WDATA = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_RDATA = 4'h4;
   localparam logic [3:0] ADDR_SLEEP = 4'h5;

   // Command codes written to ADDR_CTRL bits 2:0
   localparam logic [2:0] CMD_READ = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_SAVE = 3'h3;
   localparam logic [2:0] CMD_RESTORE = 3'h4;
   localparam logic [2:0] CMD_AS_OFF = 3'h5;
   localparam logic [2:0] CMD_AS_ON = 3'h6;

   // Field positions
   localparam int CTRL_BMASK_LO = 4;
   localparam int CTRL_BMASK_HI = 5;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DEV_BUSY = 1;
   localparam int STAT_SLEEP = 2;

   // Special-function sequence addresses
   localparam logic [19:0] SEQ_A1 = 20'h04e38;
   localparam logic [19:0] SEQ_A2 = 20'h0b1c7;
   localparam logic [19:0] SEQ_A3 = 20'h083e0;
   localparam logic [19:0] SEQ_A4 = 20'h07c1f;
   localparam logic [19:0] SEQ_A5 = 20'h0703f;
   localparam logic [19:0] SEQ_SAVE = 20'h08fc0;
   localparam logic [19:0] SEQ_RESTORE = 20'h04c63;
   localparam logic [19:0] SEQ_AS_OFF = 20'h08b45;
   localparam logic [19:0] SEQ_AS_ON = 20'h04b46;

   // Timing
   localparam int CLK_MHZ = 100;
   localparam int ACCESS_NS = 50;
   localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int WAKE_US = 20;
   localparam int WAKE_CYC_DEF = WAKE_US * CLK_MHZ;
   localparam int POST_BUSY_NS = 20;
   localparam int POST_BUSY_CYC = (POST_BUSY_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   localparam logic [15:0] DATA_RESET = 16'h0000;

   // Pins toward the memory
   typedef struct packed {
      logic first_select_n;
      logic second_select;
      logic write_n;
      logic output_en_n;
      logic upper_byte_sel_n;
      logic lower_byte_sel_n;
      logic sleep_request_n;
   } nvsq_ctl_t;

   localparam nvsq_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage : nvsq_pkg

// ==== hw/nvsq_sync.sv ====
// Two-flop synchroniser for one pin
module nvsq_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Pin and synced level
   input wire logic pin,
   output logic level
);
   logic meta_q;
   logic meta_d;
   logic level_q;
   logic level_d;

   always_comb begin
      meta_d = pin;
      level_d = meta_q;
   end

   // Idle level of the pins watched is high
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= 1'b1;
         level_q <= 1'b1;
      end else begin
         meta_q <= meta_d;
         level_q <= level_d;
      end
   end

   assign level = level_q;

endmodule : nvsq_sync

// ==== hw/nvsq_host.sv ====
// Host controller driving a nonvolatile SRAM through its pins
// What this block does
// - Sequence opens reads 4E38, B1C7, 83E0
// - Fourth read 7C1F, fifth 703F
// - Six addresses consecutive, listed order
// - Write strobe high across all six
// - Reads select- or output-enable-controlled
// - Save after changing auto-save setting (left to software; no save issued here)
// - Wait wake delay after sleep release (replaced by the post-busy delay if the device signals busy during the wait)
module nvsq_host #(
   parameter int WAKE_CYC = nvsq_pkg::WAKE_CYC_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Software port
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   // Memory pins
   output nvsq_pkg::nvsq_ctl_t mem_ctl,
   output logic [19:0] mem_addr,
   input wire logic [15:0] mem_dq_in,
   output logic [15:0] mem_dq_out,
   output logic mem_dq_oe,
   input wire logic save_busy_n_in
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_SETUP = 5'b00010,
      ST_STROBE = 5'b00100,
      ST_GAP = 5'b01000,
      ST_WAIT = 5'b10000
   } nvsq_state_t;

   nvsq_state_t st_q, st_d;
   nvsq_pkg::nvsq_ctl_t ctl_q, ctl_d;
   logic [19:0] addr_q, addr_d;
   logic [19:0] op_addr_q, op_addr_d;
   logic [15:0] wdata_q, wdata_d;
   logic [15:0] rdata_q, rdata_d;
   logic [1:0] bmask_q, bmask_d;
   logic [2:0] cmd_q, cmd_d;
   logic [2:0] step_q, step_d;
   logic oe_q, oe_d;
   logic sleep_q, sleep_d;
   logic [nvsq_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [31:0] sw_rdata_q, sw_rdata_d;
   logic busy_sync;

   nvsq_sync u_busy_sync (
      .clk(clk),
      .resetn(resetn),
      .pin(save_busy_n_in),
      .level(busy_sync)
   );

   // Sequence address for a step; the sixth depends on the command
   function automatic logic [19:0] seq_addr(input logic [2:0] step, input logic [2:0] cmd);
      case (step)
         3'h0: seq_addr = nvsq_pkg::SEQ_A1;
         3'h1: seq_addr = nvsq_pkg::SEQ_A2;
         3'h2: seq_addr = nvsq_pkg::SEQ_A3;
         3'h3: seq_addr = nvsq_pkg::SEQ_A4;
         3'h4: seq_addr = nvsq_pkg::SEQ_A5;
         default: begin
            if (cmd == nvsq_pkg::CMD_SAVE) seq_addr = nvsq_pkg::SEQ_SAVE;
            else if (cmd == nvsq_pkg::CMD_RESTORE) seq_addr = nvsq_pkg::SEQ_RESTORE;
            else if (cmd == nvsq_pkg::CMD_AS_OFF) seq_addr = nvsq_pkg::SEQ_AS_OFF;
            else seq_addr = nvsq_pkg::SEQ_AS_ON;
         end
      endcase
   endfunction : seq_addr

   function automatic logic is_seq(input logic [2:0] cmd);
      is_seq = (cmd >= nvsq_pkg::CMD_SAVE) && (cmd <= nvsq_pkg::CMD_AS_ON);
   endfunction : is_seq

   wire logic cmd_go = sw_wr && (sw_addr == nvsq_pkg::ADDR_CTRL) && (st_q == ST_IDLE)
      && !sleep_q;

   always_comb begin
      st_d = st_q;
      ctl_d = ctl_q;
      addr_d = addr_q;
      op_addr_d = op_addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      bmask_d = bmask_q;
      cmd_d = cmd_q;
      step_d = step_q;
      oe_d = oe_q;
      sleep_d = sleep_q;
      cnt_d = cnt_q;
      // Software register writes
      if (sw_wr && st_q == ST_IDLE) begin
         if (sw_addr == nvsq_pkg::ADDR_ADDR) begin
            op_addr_d = sw_wdata[19:0];
         end else if (sw_addr == nvsq_pkg::ADDR_WDATA) begin
            wdata_d = sw_wdata[15:0];
         end else if (sw_addr == nvsq_pkg::ADDR_SLEEP) begin
            // Sleep entry and release; release is followed by the wake wait
            if (sw_wdata[0] && !sleep_q) begin
               sleep_d = 1'b1;
               ctl_d = nvsq_pkg::CTL_IDLE;
               ctl_d.sleep_request_n = 1'b0;
            end else if (!sw_wdata[0] && sleep_q) begin
               sleep_d = 1'b0;
               ctl_d.sleep_request_n = 1'b1;
               cnt_d = nvsq_pkg::CNT_W'(WAKE_CYC);
               st_d = ST_WAIT;
            end
         end
      end
      case (st_q)
         ST_IDLE: begin
            // While sleeping no access is started at all
            if (cmd_go) begin
               cmd_d = sw_wdata[2:0];
               bmask_d = {sw_wdata[nvsq_pkg::CTRL_BMASK_HI], sw_wdata[nvsq_pkg::CTRL_BMASK_LO]};
               step_d = 3'h0;
               if (sw_wdata[2:0] == nvsq_pkg::CMD_READ
                   || sw_wdata[2:0] == nvsq_pkg::CMD_WRITE || is_seq(sw_wdata[2:0])) begin
                  st_d = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            // Address settles before select; write strobe stays high for reads
            addr_d = is_seq(cmd_q) ? seq_addr(step_q, cmd_q) : op_addr_q;
            ctl_d.first_select_n = 1'b1;
            ctl_d.second_select = 1'b0;
            ctl_d.write_n = 1'b1;
            ctl_d.output_en_n = 1'b1;
            ctl_d.upper_byte_sel_n = is_seq(cmd_q) ? 1'b0 : !bmask_q[1];
            ctl_d.lower_byte_sel_n = is_seq(cmd_q) ? 1'b0 : !bmask_q[0];
            oe_d = (cmd_q == nvsq_pkg::CMD_WRITE);
            cnt_d = nvsq_pkg::CNT_W'(nvsq_pkg::ACCESS_CYC);
            st_d = ST_STROBE;
         end
         ST_STROBE: begin
            // Select-controlled cycle: both selects asserted together
            ctl_d.first_select_n = 1'b0;
            ctl_d.second_select = 1'b1;
            ctl_d.write_n = (cmd_q == nvsq_pkg::CMD_WRITE) ? 1'b0 : 1'b1;
            ctl_d.output_en_n = (cmd_q == nvsq_pkg::CMD_WRITE);
            if (cnt_q != nvsq_pkg::CNT_ZERO) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               if (cmd_q != nvsq_pkg::CMD_WRITE) begin
                  rdata_d = mem_dq_in;
               end
               ctl_d = nvsq_pkg::CTL_IDLE;
               oe_d = 1'b0;
               st_d = ST_GAP;
            end
         end
         ST_GAP: begin
            // No other access is let in between the six sequence reads
            if (is_seq(cmd_q) && step_q != 3'h5) begin
               step_d = step_q + 3'h1;
               st_d = ST_SETUP;
            end else begin
               cnt_d = nvsq_pkg::CNT_W'(nvsq_pkg::POST_BUSY_CYC);
               st_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // Hold off while the device signals busy, then the post-busy delay
            if (!busy_sync) begin
               cnt_d = nvsq_pkg::CNT_W'(nvsq_pkg::POST_BUSY_CYC);
            end else if (cnt_q != nvsq_pkg::CNT_ZERO) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               // A changed auto-save setting needs a save to persist; software issues it
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_comb begin
      sw_rdata_d = 32'h00000000;
      if (sw_rd) begin
         if (sw_addr == nvsq_pkg::ADDR_ADDR) begin
            sw_rdata_d = {12'h000, op_addr_q};
         end else if (sw_addr == nvsq_pkg::ADDR_WDATA) begin
            sw_rdata_d = {16'h0000, wdata_q};
         end else if (sw_addr == nvsq_pkg::ADDR_STATUS) begin
            sw_rdata_d[nvsq_pkg::STAT_BUSY] = (st_q != ST_IDLE);
            sw_rdata_d[nvsq_pkg::STAT_DEV_BUSY] = !busy_sync;
            sw_rdata_d[nvsq_pkg::STAT_SLEEP] = sleep_q;
         end else if (sw_addr == nvsq_pkg::ADDR_RDATA) begin
            sw_rdata_d = {16'h0000, rdata_q};
         end else if (sw_addr == nvsq_pkg::ADDR_SLEEP) begin
            sw_rdata_d = {31'h00000000, sleep_q};
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= ST_IDLE;
         ctl_q <= nvsq_pkg::CTL_IDLE;
         addr_q <= 20'h00000;
         op_addr_q <= 20'h00000;
         wdata_q <= nvsq_pkg::DATA_RESET;
         rdata_q <= nvsq_pkg::DATA_RESET;
         bmask_q <= 2'h0;
         cmd_q <= 3'h0;
         step_q <= 3'h0;
         oe_q <= 1'b0;
         sleep_q <= 1'b0;
         cnt_q <= nvsq_pkg::CNT_ZERO;
         sw_rdata_q <= 32'h00000000;
      end else begin
         st_q <= st_d;
         ctl_q <= ctl_d;
         addr_q <= addr_d;
         op_addr_q <= op_addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         bmask_q <= bmask_d;
         cmd_q <= cmd_d;
         step_q <= step_d;
         oe_q <= oe_d;
         sleep_q <= sleep_d;
         cnt_q <= cnt_d;
         sw_rdata_q <= sw_rdata_d;
      end
   end

   assign mem_ctl = ctl_q;
   assign mem_addr = addr_q;
   assign mem_dq_out = wdata_q;
   assign mem_dq_oe = oe_q;
   assign sw_rdata = sw_rdata_q;

   property p_select_pair;
      @(posedge clk) disable iff (!resetn)
      (mem_ctl.first_select_n == 1'b0) |-> (mem_ctl.second_select == 1'b1);
   endproperty
   a_select_pair: assert property (p_select_pair)
      else $error("first select low without second select high");
   property p_seq_no_write;
      @(posedge clk) disable iff (!resetn)
      (is_seq(cmd_q) && st_q != ST_IDLE) |-> mem_ctl.write_n;
   endproperty
   a_seq_no_write: assert property (p_seq_no_write)
      else $error("write strobe low during sequence");
   property p_sleep_quiet;
      @(posedge clk) disable iff (!resetn)
      (!mem_ctl.sleep_request_n) |-> mem_ctl.first_select_n;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet)
      else $error("access while sleep pin low");
   property p_seq_first;
      @(posedge clk) disable iff (!resetn)
      (st_q == ST_STROBE && is_seq(cmd_q) && step_q == 3'h0) |-> mem_addr == nvsq_pkg::SEQ_A1;
   endproperty
   a_seq_first: assert property (p_seq_first)
      else $error("sequence does not open at first address");
   property p_wake_wait;
      @(posedge clk) disable iff (!resetn)
      $rose(mem_ctl.sleep_request_n) |-> st_q == ST_WAIT;
   endproperty
   a_wake_wait: assert property (p_wake_wait)
      else $error("no wake wait after sleep release");
   property p_seq_fourth;
      @(posedge clk) disable iff (!resetn)
      (st_q == ST_STROBE && is_seq(cmd_q) && step_q == 3'h3) |-> mem_addr == nvsq_pkg::SEQ_A4;
   endproperty
   a_seq_fourth: assert property (p_seq_fourth)
      else $error("fourth sequence address wrong");
   property p_busy_hold;
      @(posedge clk) disable iff (!resetn)
      (st_q == ST_WAIT && !busy_sync) |=> st_q == ST_WAIT;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("left wait while device busy");
   property p_oe_write;
      @(posedge clk) disable iff (!resetn)
      (mem_dq_oe) |-> cmd_q == nvsq_pkg::CMD_WRITE;
   endproperty
   a_oe_write: assert property (p_oe_write)
      else $error("data driven outside a write");

endmodule : nvsq_host

// ==== sim/nvsq_dev.sv ====
// Behavioural model of the nonvolatile SRAM as seen at its pins
module nvsq_dev #(
   parameter int SAVE_CYC = 12
) (
   // Clock
   input wire logic clk,
   // Memory pins
   input wire nvsq_pkg::nvsq_ctl_t ctl,
   input wire logic [19:0] addr,
   input wire logic [15:0] dq_h,
   output logic [15:0] dq,
   output logic busy_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [int];
   logic [15:0] nv [int];
   logic [19:0] sq [5] = '{nvsq_pkg::SEQ_A1, nvsq_pkg::SEQ_A2, nvsq_pkg::SEQ_A3,
      nvsq_pkg::SEQ_A4, nvsq_pkg::SEQ_A5};
   logic as_q = 1'b1;
   logic wl_q = 1'b0;
   logic act_q = 1'b0;
   logic rd_q = 1'b0;
   logic slp_q = 1'b0;
   logic [19:0] a_q = 20'h00000;
   logic [15:0] last = 16'h0000;
   logic [15:0] d;
   int step = 0;
   int busy = 0;
   wire logic sel = !ctl.first_select_n && ctl.second_select;
   wire logic act = sel && (!ctl.output_en_n || !ctl.write_n) && busy == 0
      && ctl.sleep_request_n;
   wire logic drv = act && ctl.write_n && !ctl.output_en_n;
   function automatic logic [15:0] rdm(input logic [19:0] a);
      return mem.exists(a) ? mem[a] : 16'h0000;
   endfunction : rdm
   // Released bus shows the inverse, so a stale sample never matches
   assign dq = drv ? rdm(addr) : ~last;
   assign busy_n = (busy == 0);
   task automatic nvop(input logic save);
      if (save) nv = mem;
      else mem = nv;
      wl_q = 1'b0;
      busy = SAVE_CYC;
   endtask : nvop
   always @(posedge clk) begin
      if (busy > 0) busy--;
      if (!ctl.sleep_request_n && !slp_q && wl_q) nvop(1'b1);
      slp_q = !ctl.sleep_request_n;
      if (act && !ctl.write_n) begin
         d = rdm(addr);
         if (!ctl.lower_byte_sel_n) d[7:0] = dq_h[7:0];
         if (!ctl.upper_byte_sel_n) d[15:8] = dq_h[15:8];
         mem[addr] = d;
         wl_q = 1'b1;
         step = 0;
      end
      if (act_q && !act && rd_q) begin
         if (step == 5) begin
            step = 0;
            case (a_q[14:2])
               nvsq_pkg::SEQ_SAVE[14:2]: nvop(1'b1);
               nvsq_pkg::SEQ_RESTORE[14:2]: nvop(1'b0);
               nvsq_pkg::SEQ_AS_OFF[14:2]: as_q = 1'b0;
               nvsq_pkg::SEQ_AS_ON[14:2]: as_q = 1'b1;
               default: ;
            endcase
         end else if (a_q[14:2] == sq[step][14:2]) step++;
         else step = (a_q[14:2] == sq[0][14:2]) ? 1 : 0;
      end
      if (act) begin
         a_q = addr;
         rd_q = ctl.write_n;
      end
      if (drv) last = dq;
      act_q = act;
   end
endmodule : nvsq_dev

// ==== sim/nvsq_host_bench.sv ====
// Self-checking bench for the nonvolatile SRAM host controller
module nvsq_host_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WAKE = 10;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h00000000;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [31:0] sw_rdata;
   nvsq_pkg::nvsq_ctl_t mem_ctl;
   logic [19:0] mem_addr;
   logic [15:0] mem_dq_in;
   logic [15:0] mem_dq_out;
   logic mem_dq_oe;
   logic busy_n;
   logic seen_busy = 1'b0;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   // Undriven host side reads as garbage, so a missing enable corrupts writes
   wire logic [15:0] bus_h = mem_dq_oe ? mem_dq_out : ~mem_dq_out;
   nvsq_host #(.WAKE_CYC(WAKE)) u_nvsq_host (.clk(clk), .resetn(resetn), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
      .mem_ctl(mem_ctl), .mem_addr(mem_addr), .mem_dq_in(mem_dq_in),
      .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .save_busy_n_in(busy_n));
   nvsq_dev u_nvsq_dev (.clk(clk), .ctl(mem_ctl), .addr(mem_addr), .dq_h(bus_h),
      .dq(mem_dq_in), .busy_n(busy_n));
   always #5 clk = ~clk;
   task automatic results;
      if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (busy_n === 1'b0) seen_busy <= 1'b1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask : rd
   task automatic idle;
      logic [31:0] s;
      int n;
      s = 32'h00000001;
      n = 0;
      while (s[nvsq_pkg::STAT_BUSY] !== 1'b0 && n < 500) begin
         rd(nvsq_pkg::ADDR_STATUS, s);
         n++;
      end
      chk(s[nvsq_pkg::STAT_BUSY], 32'h0);
   endtask : idle
   task automatic cmd(input logic [2:0] c, input logic [19:0] a, input logic [15:0] d,
      input logic [1:0] m = 2'b11);
      wr(nvsq_pkg::ADDR_ADDR, {12'h000, a});
      wr(nvsq_pkg::ADDR_WDATA, {16'h0000, d});
      wr(nvsq_pkg::ADDR_CTRL, {26'h0, m, 1'b0, c});
      idle();
   endtask : cmd
   task automatic rdchk(input logic [19:0] a, input logic [15:0] e);
      logic [31:0] g;
      cmd(nvsq_pkg::CMD_READ, a, 16'h0000);
      rd(nvsq_pkg::ADDR_RDATA, g);
      chk(g, {16'h0000, e});
   endtask : rdchk
   task automatic t_rw;
      logic [31:0] g;
      chk({25'h0, mem_ctl}, {25'h0, nvsq_pkg::CTL_IDLE});
      chk(u_nvsq_dev.as_q, 32'h1);
      rdchk(20'h00123, 16'h0000);
      cmd(nvsq_pkg::CMD_WRITE, 20'h00123, 16'h1234);
      cmd(nvsq_pkg::CMD_WRITE, 20'h00123, 16'habcd, 2'b01);
      rdchk(20'h00123, 16'h12cd);
      cmd(nvsq_pkg::CMD_WRITE, 20'h00123, 16'h5678, 2'b10);
      rdchk(20'h00123, 16'h56cd);
      rd(nvsq_pkg::ADDR_ADDR, g);
      chk(g, 32'h00000123);
      rd(nvsq_pkg::ADDR_WDATA, g);
      chk(g, 32'h00000000);
   endtask : t_rw
   task automatic t_nv;
      cmd(nvsq_pkg::CMD_WRITE, 20'h00010, 16'h5a5a);
      seen_busy = 1'b0;
      cmd(nvsq_pkg::CMD_SAVE, 20'h00000, 16'h0000);
      chk(seen_busy, 32'h1);
      cmd(nvsq_pkg::CMD_WRITE, 20'h00010, 16'ha5a5);
      cmd(nvsq_pkg::CMD_RESTORE, 20'h00000, 16'h0000);
      rdchk(20'h00010, 16'h5a5a);
   endtask : t_nv
   task automatic t_as;
      cmd(nvsq_pkg::CMD_AS_OFF, 20'h00000, 16'h0000);
      chk(u_nvsq_dev.as_q, 32'h0);
      cmd(nvsq_pkg::CMD_SAVE, 20'h00000, 16'h0000);
      cmd(nvsq_pkg::CMD_AS_ON, 20'h00000, 16'h0000);
      chk(u_nvsq_dev.as_q, 32'h1);
      cmd(nvsq_pkg::CMD_SAVE, 20'h00000, 16'h0000);
   endtask : t_as
   task automatic t_sleep;
      int c0;
      logic [31:0] s;
      cmd(nvsq_pkg::CMD_WRITE, 20'h00020, 16'h7e7e);
      seen_busy = 1'b0;
      wr(nvsq_pkg::ADDR_SLEEP, 32'h1);
      repeat (3) @(posedge clk);
      chk(mem_ctl.sleep_request_n, 32'h0);
      // A command while asleep must not reach the pins
      wr(nvsq_pkg::ADDR_CTRL, {29'h0, nvsq_pkg::CMD_READ});
      repeat (30) @(posedge clk);
      chk(mem_ctl.first_select_n, 32'h1);
      rd(nvsq_pkg::ADDR_STATUS, s);
      chk(s[nvsq_pkg::STAT_SLEEP], 32'h1);
      rd(nvsq_pkg::ADDR_SLEEP, s);
      chk(s, 32'h00000001);
      chk(seen_busy, 32'h1);
      wr(nvsq_pkg::ADDR_SLEEP, 32'h0);
      c0 = cyc;
      idle();
      chk(32'(cyc - c0 >= WAKE), 32'h1);
      cmd(nvsq_pkg::CMD_WRITE, 20'h00020, 16'h0000);
      cmd(nvsq_pkg::CMD_RESTORE, 20'h00000, 16'h0000);
      rdchk(20'h00020, 16'h7e7e);
      seen_busy = 1'b0;
      wr(nvsq_pkg::ADDR_SLEEP, 32'h1);
      repeat (30) @(posedge clk);
      chk(seen_busy, 32'h0);
      wr(nvsq_pkg::ADDR_SLEEP, 32'h0);
      idle();
   endtask : t_sleep
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_rw();
      t_nv();
      t_as();
      t_sleep();
      results();
   end
endmodule : nvsq_host_bench
